// *** core/compass_i2c_cmd.sv ***
// Two-wire slave and command interpreter of the digital compass
`timescale 1ns/1ps
`default_nettype none
`include "compass_cfg.svh"
module compass_i2c_cmd #(
	parameter int unsigned NV_CYC = `T_NV_US * `CLK_MHZ,
	parameter int unsigned WAKE_CYC = `T_WAKE_US * `CLK_MHZ,
	parameter int unsigned SAVE_CYC = `T_SAVE_US * `CLK_MHZ,
	parameter int unsigned HDG_CYC = `T_HDG_MS * `US_PER_MS * `CLK_MHZ,
	parameter int unsigned CALX_CYC = `T_CALX_MS * `US_PER_MS * `CLK_MHZ,
	parameter logic [7:0] FW_VERSION = 8'h02 // Arbitrary value
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic [15:0] heading_in,
	output logic meas_start,
	output logic offset_update,
	output logic cal_active,
	output logic cal_finish,
	output logic asleep,
	output compass_pkg::run_mode_e run_mode,
	output logic [7:0] out_mode,
	output logic [15:0] x_offset,
	output logic [15:0] y_offset,
	output logic [7:0] settle_ms,
	output logic [7:0] sum_count
);
	import compass_pkg::*;

	localparam int unsigned SHORT_CYC = `T_SHORT_US * `CLK_MHZ;

	logic scl_s, sda_s, scl_q_r, sda_q_r;
	logic scl_rise, scl_fall, start_c, stop_c;
	bus_state_e st_r, st_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic rd_r, rd_nxt, mack_r, mack_nxt, ridx_r, ridx_nxt;
	logic oe_r, oe_nxt;
	logic [1:0] bidx_r, bidx_nxt;
	logic [7:0] b0_r, b0_nxt, b1_r, b1_nxt, b2_r, b2_nxt;
	logic exec_c, rd_end_c, busy, tdone;
	logic [7:0] nv_r [0:`NV_WORDS-1];
	logic [7:0] ram_mem [0:255];
	logic nv_we, ram_we;
	logic [3:0] nv_wa;
	logic [7:0] opm_r, opm_nxt, outm_r, outm_nxt;
	logic [7:0] resp0_r, resp0_nxt, resp1_r, resp1_nxt;
	logic init_r, init_nxt, hdg_r, hdg_nxt;
	logic sleep_r, sleep_nxt, cal_r, cal_nxt;
	logic meas_r, meas_nxt, ofs_r, ofs_nxt, calf_r, calf_nxt;
	logic tload;
	logic [`TMR_W-1:0] tcyc;
	run_mode_e mode_r, mode_nxt;

	// Both bus lines come from another party's clock
	pin_sync #(
		.W(2)
	) u_sync (
		.clk(clk),
		.rst_b(rst_b),
		.din({scl, sda_in}),
		.dout({scl_s, sda_s})
	);

	// Holds every response but the 0x43 result outside standby, and NACKs the bus while a command runs
	cmd_timer u_timer (
		.clk(clk),
		.rst_b(rst_b),
		.load(tload),
		.cycles(tcyc),
		.busy(busy),
		.done(tdone)
	);

	// Bus edges and conditions, seen on the synchronised lines only
	assign scl_rise = scl_s & ~scl_q_r;
	assign scl_fall = ~scl_s & scl_q_r;
	assign start_c = scl_s & scl_q_r & sda_q_r & ~sda_s;
	assign stop_c = scl_s & scl_q_r & ~sda_q_r & sda_s;
	// A write only acts once its stop arrives, so arguments are complete
	assign exec_c = stop_c & ~rd_r & (bidx_r != 2'h0);
	// Master NACK ends a read
	assign rd_end_c = (st_r == S_RACK) & scl_fall & ~mack_r;

	// Serial engine: address, write bytes, read bytes, acknowledges
	always_comb begin
		st_nxt = st_r;
		sh_nxt = sh_r;
		cnt_nxt = cnt_r;
		rd_nxt = rd_r;
		mack_nxt = mack_r;
		ridx_nxt = ridx_r;
		oe_nxt = oe_r;
		bidx_nxt = bidx_r;
		b0_nxt = b0_r;
		b1_nxt = b1_r;
		b2_nxt = b2_r;
		if (start_c) begin
			st_nxt = S_ADDR;
			cnt_nxt = 4'h0;
			oe_nxt = 1'b0;
			bidx_nxt = 2'h0;
		end else if (stop_c) begin
			st_nxt = S_IDLE;
			oe_nxt = 1'b0;
		end else begin
			unique case (st_r)
				S_IDLE: begin
					oe_nxt = 1'b0;
				end
				S_ADDR, S_WR: begin
					if (scl_rise) begin
						sh_nxt = {sh_r[6:0], sda_s};
						cnt_nxt = cnt_r + 4'h1;
					end else if (scl_fall && cnt_r == 4'h8) begin
						cnt_nxt = 4'h0;
						if (st_r == S_ADDR) begin
							// Busy device stays off the bus
							if (sh_r[7:1] == nv_r[`NV_ADDR][7:1] && !busy) begin
								st_nxt = S_AACK;
								rd_nxt = sh_r[0];
								oe_nxt = 1'b1;
							end else begin
								st_nxt = S_IDLE;
							end
						end else begin
							st_nxt = S_WACK;
							oe_nxt = 1'b1;
							// Bytes past the third are acked and dropped
							if (bidx_r == 2'h0) begin
								b0_nxt = sh_r;
							end
							if (bidx_r == 2'h1) begin
								b1_nxt = sh_r;
							end
							if (bidx_r == 2'h2) begin
								b2_nxt = sh_r;
							end
							if (bidx_r != 2'h3) begin
								bidx_nxt = bidx_r + 2'h1;
							end
						end
					end
				end
				S_AACK, S_WACK: begin
					if (scl_fall) begin
						if (st_r == S_AACK && rd_r) begin
							// First data bit follows the ack at once
							st_nxt = S_RD;
							sh_nxt = resp0_r;
							oe_nxt = ~resp0_r[7];
							cnt_nxt = 4'h1;
							ridx_nxt = 1'b1;
						end else begin
							st_nxt = S_WR;
							oe_nxt = 1'b0;
						end
					end
				end
				S_RD: begin
					if (scl_fall) begin
						if (cnt_r == 4'h8) begin
							st_nxt = S_RACK;
							oe_nxt = 1'b0;
						end else begin
							sh_nxt = {sh_r[6:0], 1'b0};
							oe_nxt = ~sh_r[6];
							cnt_nxt = cnt_r + 4'h1;
						end
					end
				end
				S_RACK: begin
					if (scl_rise) begin
						mack_nxt = ~sda_s;
					end else if (scl_fall) begin
						if (mack_r) begin
							// Second byte follows in the same read
							st_nxt = S_RD;
							sh_nxt = ridx_r ? resp1_r : `NO_DATA;
							oe_nxt = ridx_r ? ~resp1_r[7] : 1'b0;
							cnt_nxt = 4'h1;
							ridx_nxt = 1'b0;
						end else begin
							st_nxt = S_IDLE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
			st_r <= S_IDLE;
			sh_r <= 8'h00;
			cnt_r <= 4'h0;
			rd_r <= 1'b0;
			mack_r <= 1'b0;
			ridx_r <= 1'b0;
			oe_r <= 1'b0;
			bidx_r <= 2'h0;
			b0_r <= 8'h00;
			b1_r <= 8'h00;
			b2_r <= 8'h00;
		end else begin
			scl_q_r <= scl_s;
			sda_q_r <= sda_s;
			st_r <= st_nxt;
			sh_r <= sh_nxt;
			cnt_r <= cnt_nxt;
			rd_r <= rd_nxt;
			mack_r <= mack_nxt;
			ridx_r <= ridx_nxt;
			oe_r <= oe_nxt;
			bidx_r <= bidx_nxt;
			b0_r <= b0_nxt;
			b1_r <= b1_nxt;
			b2_r <= b2_nxt;
		end
	end

	// Command execution; modes do not gate decoding, as outcome there
	// is the host's risk
	always_comb begin
		opm_nxt = opm_r;
		outm_nxt = outm_r;
		resp0_nxt = resp0_r;
		resp1_nxt = resp1_r;
		init_nxt = 1'b1;
		hdg_nxt = hdg_r;
		sleep_nxt = sleep_r;
		cal_nxt = cal_r;
		meas_nxt = 1'b0;
		ofs_nxt = 1'b0;
		calf_nxt = 1'b0;
		tload = 1'b0;
		tcyc = '0;
		nv_we = 1'b0;
		nv_wa = b1_r[3:0];
		ram_we = 1'b0;
		// Saved mode becomes the live mode once after power-up
		if (!init_r) begin
			opm_nxt = nv_r[`NV_OPMODE];
		end
		// Heading lands in the buffer when the delay ends
		if (tdone && hdg_r) begin
			resp0_nxt = heading_in[15:8];
			resp1_nxt = heading_in[7:0];
			hdg_nxt = 1'b0;
		end
		// Query mode refreshes once the host has read
		if (rd_end_c && mode_r == MODE_QUERY) begin
			meas_nxt = 1'b1;
		end
		// Asleep, only the wake opcode is honoured
		if (exec_c && (!sleep_r || b0_r == `OP_WAKE)) begin
			case (b0_r)
				`OP_NV_WR: begin
					// Version is read-only; sum count keeps its range
					if (bidx_r == 2'h3 && b1_r <= 8'(`NV_OPMODE)
							&& b1_r != 8'(`NV_VERSION)
							&& (b1_r != 8'(`NV_SUM)
							|| (b2_r >= `SUM_MIN && b2_r <= `SUM_MAX))) begin
						nv_we = 1'b1;
					end
					tload = 1'b1;
					tcyc = `TMR_W'(NV_CYC);
				end
				`OP_NV_RD: begin
					resp0_nxt = (b1_r <= 8'(`NV_OPMODE)) ? nv_r[b1_r[3:0]]
						: `NO_DATA;
					tload = 1'b1;
					tcyc = `TMR_W'(NV_CYC);
				end
				`OP_RAM_WR: begin
					if (bidx_r == 2'h3) begin
						ram_we = 1'b1;
						if (b1_r == `RAM_OPMODE) begin
							opm_nxt = b2_r;
						end
						if (b1_r == `RAM_OUTMODE) begin
							outm_nxt = b2_r;
						end
					end
					tload = 1'b1;
					tcyc = `TMR_W'(NV_CYC);
				end
				`OP_RAM_RD: begin
					if (b1_r == `RAM_OPMODE) begin
						resp0_nxt = opm_r;
					end else if (b1_r == `RAM_OUTMODE) begin
						resp0_nxt = outm_r;
					end else begin
						resp0_nxt = ram_mem[b1_r];
					end
					tload = 1'b1;
					tcyc = `TMR_W'(NV_CYC);
				end
				`OP_SLEEP: begin
					if (bidx_r == 2'h1) begin
						sleep_nxt = 1'b1;
						tload = 1'b1;
						tcyc = `TMR_W'(SHORT_CYC);
					end
				end
				`OP_WAKE: begin
					sleep_nxt = 1'b0;
					tload = 1'b1;
					tcyc = `TMR_W'(WAKE_CYC);
				end
				`OP_OFFSET: begin
					ofs_nxt = 1'b1;
					tload = 1'b1;
					tcyc = `TMR_W'(HDG_CYC);
				end
				`OP_CAL_IN: begin
					if (mode_r == MODE_STANDBY) begin
						cal_nxt = 1'b1;
						tload = 1'b1;
						tcyc = `TMR_W'(SHORT_CYC);
					end else begin
						// Latest result is ready at once
						resp0_nxt = heading_in[15:8];
						resp1_nxt = heading_in[7:0];
					end
				end
				`OP_CAL_OUT: begin
					cal_nxt = 1'b0;
					calf_nxt = cal_r;
					tload = 1'b1;
					tcyc = `TMR_W'(CALX_CYC);
				end
				`OP_SAVE: begin
					nv_we = 1'b1;
					nv_wa = `NV_OPMODE;
					tload = 1'b1;
					tcyc = `TMR_W'(SAVE_CYC);
				end
				`OP_HEADING: begin
					// Standby measures only here
					meas_nxt = 1'b1;
					hdg_nxt = 1'b1;
					tload = 1'b1;
					tcyc = `TMR_W'(HDG_CYC);
				end
				default: begin
					tload = 1'b0;
				end
			endcase
		end
		unique case (opm_nxt[1:0])
			2'h1: mode_nxt = MODE_QUERY;
			2'h2: mode_nxt = MODE_CONT;
			default: mode_nxt = MODE_STANDBY;
		endcase
	end

	// Storage resets to factory contents; RAM holds no reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			nv_r[`NV_ADDR] <= `RST_ADDR;
			nv_r[`NV_XOFS_H] <= `RST_OFS;
			nv_r[`NV_XOFS_L] <= `RST_OFS;
			nv_r[`NV_YOFS_H] <= `RST_OFS;
			nv_r[`NV_YOFS_L] <= `RST_OFS;
			nv_r[`NV_SETTLE] <= `RST_SETTLE;
			nv_r[`NV_SUM] <= `RST_SUM;
			nv_r[`NV_VERSION] <= FW_VERSION;
			nv_r[`NV_OPMODE] <= `RST_OPMODE;
		end else if (nv_we) begin
			nv_r[nv_wa] <= (nv_wa == `NV_OPMODE && b0_r == `OP_SAVE)
				? opm_r : b2_r;
		end
	end

	always_ff @(posedge clk) begin
		if (ram_we) begin
			ram_mem[b1_r] <= b2_r;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			opm_r <= `RST_OPMODE;
			outm_r <= `RST_OUTMODE;
			resp0_r <= `NO_DATA;
			resp1_r <= `NO_DATA;
			init_r <= 1'b0;
			hdg_r <= 1'b0;
			sleep_r <= 1'b0;
			cal_r <= 1'b0;
			meas_r <= 1'b0;
			ofs_r <= 1'b0;
			calf_r <= 1'b0;
			mode_r <= MODE_STANDBY;
		end else begin
			opm_r <= opm_nxt;
			outm_r <= outm_nxt;
			resp0_r <= resp0_nxt;
			resp1_r <= resp1_nxt;
			init_r <= init_nxt;
			hdg_r <= hdg_nxt;
			sleep_r <= sleep_nxt;
			cal_r <= cal_nxt;
			meas_r <= meas_nxt;
			ofs_r <= ofs_nxt;
			calf_r <= calf_nxt;
			mode_r <= mode_nxt;
		end
	end

	// Open drain: only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe = oe_r;
	assign meas_start = meas_r;
	assign offset_update = ofs_r;
	assign cal_active = cal_r;
	assign cal_finish = calf_r;
	assign asleep = sleep_r;
	assign run_mode = mode_r;
	assign out_mode = outm_r;
	// Offsets are stored high byte first
	assign x_offset = {nv_r[`NV_XOFS_H], nv_r[`NV_XOFS_L]};
	assign y_offset = {nv_r[`NV_YOFS_H], nv_r[`NV_YOFS_L]};
	assign settle_ms = nv_r[`NV_SETTLE];
	assign sum_count = nv_r[`NV_SUM];
endmodule : compass_i2c_cmd
`default_nettype wire

// *** core/compass_cfg.svh ***
// Constants, opcodes, storage layout and timing of the compass interpreter
// Summary of operation
// - Standby accepts and executes every command.
// - Query/continuous commands run, outcome not guaranteed.
// - Opcode 0x53 alone sleeps; takes 10 us.
// - 0x67 plus address buffers RAM byte, 70 us.
// - 0x47, address, data writes one RAM byte.
// - 0x77, address, data writes storage, 70 us.
// - 0x72 plus address buffers stored byte, 70 us.
// - 0x41 gives two-byte heading, high first, 6 ms.
// - 0x4F updates bridge offset, busy 6 ms.
// - 0x43 in standby enters calibration, 10 us.
// - 0x45 ends calibration, busy 14 ms.
// - 0x4C saves mode byte to storage, 125 us.
// - Read drives first bit right after address ack.
// - Two pending bytes go out in one read.
// - Bus address from storage location 0, default 0x42.
// - Location 6 holds sum count 1-16, default 4.
// - Location 5 holds settling ms, default 1.
// - Locations 1-4 hold X, Y offsets, high first.
// - Mode byte RAM 0x74, saved at 8, loads at power-up.
// - Output mode RAM 0x4E, heading after power-up.
// - Standby measures only on heading command.
// - Query mode measures anew after each read.
`ifndef COMPASS_CFG_SVH
`define COMPASS_CFG_SVH
`define CLK_MHZ 100
`define US_PER_MS 1000
`define T_SHORT_US 10
`define T_NV_US 70
`define T_WAKE_US 100
`define T_SAVE_US 125
`define T_HDG_MS 6
`define T_CALX_MS 14
`define TMR_W 21
`define OP_NV_WR 8'h77
`define OP_NV_RD 8'h72
`define OP_RAM_WR 8'h47
`define OP_RAM_RD 8'h67
`define OP_SLEEP 8'h53
`define OP_WAKE 8'h57
`define OP_OFFSET 8'h4f
`define OP_CAL_IN 8'h43
`define OP_CAL_OUT 8'h45
`define OP_SAVE 8'h4c
`define OP_HEADING 8'h41
`define NV_ADDR 4'h0
`define NV_XOFS_H 4'h1
`define NV_XOFS_L 4'h2
`define NV_YOFS_H 4'h3
`define NV_YOFS_L 4'h4
`define NV_SETTLE 4'h5
`define NV_SUM 4'h6
`define NV_VERSION 4'h7
`define NV_OPMODE 4'h8
`define NV_WORDS 9
`define RAM_OPMODE 8'h74
`define RAM_OUTMODE 8'h4e
`define RST_ADDR 8'h42
`define RST_OFS 8'h00
`define RST_SETTLE 8'h01
`define RST_SUM 8'h04
`define RST_OPMODE 8'h50
`define RST_OUTMODE 8'h00
`define SUM_MIN 8'h01
`define SUM_MAX 8'h10
`define NO_DATA 8'hff
`endif

// *** core/compass_pkg.sv ***
// Types shared by the compass command interpreter
`default_nettype none
package compass_pkg;
	typedef enum logic [6:0] {
		S_IDLE = 7'h01,
		S_ADDR = 7'h02,
		S_AACK = 7'h04,
		S_WR = 7'h08,
		S_WACK = 7'h10,
		S_RD = 7'h20,
		S_RACK = 7'h40
	} bus_state_e;
	typedef enum logic [1:0] {
		MODE_STANDBY = 2'h0,
		MODE_QUERY = 2'h1,
		MODE_CONT = 2'h2
	} run_mode_e;
endpackage : compass_pkg
`default_nettype wire

// *** core/pin_sync.sv ***
// Two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int W = 2
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_r;

	// Idle bus lines float high, so both stages reset high
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_r <= '1;
			dout <= '1;
		end else begin
			meta_r <= din;
			dout <= meta_r;
		end
	end
endmodule : pin_sync
`default_nettype wire

// *** core/cmd_timer.sv ***
// Down-counter that holds the interpreter busy for a command delay
`timescale 1ns/1ps
`default_nettype none
`include "compass_cfg.svh"
module cmd_timer (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic load,
	input wire logic [`TMR_W-1:0] cycles,
	output logic busy,
	output logic done
);
	logic [`TMR_W-1:0] cnt_r;
	logic [`TMR_W-1:0] cnt_nxt;

	// A new load restarts the count
	always_comb begin
		cnt_nxt = cnt_r;
		if (load) begin
			cnt_nxt = cycles;
		end else if (cnt_r != '0) begin
			cnt_nxt = cnt_r - `TMR_W'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign busy = (cnt_r != '0);
	assign done = (cnt_r == `TMR_W'(1)); // Last busy cycle
endmodule : cmd_timer
`default_nettype wire

// *** verif/compass_i2c_cmd_monitor.sv ***
// Port-level checks of the compass command interpreter
`timescale 1ns/1ps
`default_nettype none
module compass_i2c_cmd_monitor (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic scl,
	input wire logic sda_in,
	input wire logic sda_oe,
	input wire logic [15:0] heading_in,
	input wire logic meas_start,
	input wire logic offset_update,
	input wire logic cal_active,
	input wire logic cal_finish,
	input wire logic asleep,
	input wire compass_pkg::run_mode_e run_mode,
	input wire logic [7:0] out_mode,
	input wire logic [15:0] x_offset,
	input wire logic [15:0] y_offset,
	input wire logic [7:0] settle_ms,
	input wire logic [7:0] sum_count
);
	import compass_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	// Strobes last exactly one cycle
	sequence meas_pulse_s;
		meas_start ##1 !meas_start;
	endsequence
	sequence ofs_pulse_s;
		offset_update ##1 !offset_update;
	endsequence
	// Settings only move while the bus rests after a stop
	sequence bus_rest_s;
		scl && sda_in;
	endsequence
	meas_once_a: assert property (meas_start |-> meas_pulse_s)
		else $error("measure strobe longer than one cycle");
	offset_once_a: assert property (offset_update |-> ofs_pulse_s)
		else $error("offset strobe longer than one cycle");
	cal_end_a: assert property (cal_finish |-> $past(cal_active) ##[0:2] !cal_active)
		else $error("calibration end without calibration");
	cal_entry_a: assert property ($rose(cal_active) |-> run_mode == MODE_STANDBY)
		else $error("calibration entered outside standby");
	sleep_quiet_a: assert property (asleep && $past(asleep) |-> !meas_start && !offset_update && !cal_finish)
		else $error("activity while asleep");
	sum_range_a: assert property (sum_count inside {[8'h01:8'h10]})
		else $error("sum count out of range");
	mode_legal_a: assert property (run_mode inside {MODE_STANDBY, MODE_QUERY, MODE_CONT})
		else $error("illegal run mode");
	// A standby measurement only ever follows a command frame's stop
	meas_stop_a: assert property (meas_start && run_mode == MODE_STANDBY |-> bus_rest_s)
		else $error("standby measure outside a command stop");
	cfg_at_stop_a: assert property (!$stable({x_offset, y_offset, settle_ms, sum_count, out_mode, run_mode}) |-> bus_rest_s)
		else $error("setting changed mid frame");
	sleep_at_stop_a: assert property (!$stable(asleep) |-> bus_rest_s)
		else $error("sleep state changed mid frame");
	// Data may only move while the bus clock is low
	oe_low_clock_a: assert property ($changed(sda_oe) |-> !scl)
		else $error("data pin moved while clock high");
endmodule : compass_i2c_cmd_monitor
bind compass_i2c_cmd compass_i2c_cmd_monitor mon_u (.clk, .rst_b, .scl, .sda_in, .sda_oe, .heading_in, .meas_start, .offset_update, .cal_active, .cal_finish, .asleep, .run_mode, .out_mode, .x_offset, .y_offset, .settle_ms, .sum_count);
`default_nettype wire

// *** verif/host_model.sv ***
// Bus master model: frames on the two-wire link, 80 ns bit clock
`timescale 1ns/1ps
`default_nettype none
module host_model (
	output logic scl,
	output logic sda_low,
	input wire logic sda,
	output logic [7:0] rx_data,
	output logic rx_done
);
	logic ack;
	// Lines released, clock idles high between frames
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		rx_data = 8'h00;
		rx_done = 1'b0;
	end
	// Hand each byte or acknowledge seen to the bench
	task post(input logic [7:0] v);
		rx_data = v;
		rx_done = 1'b1;
		#1 rx_done = 1'b0;
	endtask : post
	// Data changes only mid clock-low
	task put_bit(input logic b);
		#20 sda_low = !b;
		#20 scl = 1'b1;
		#40 scl = 1'b0;
	endtask : put_bit
	// Sample late in clock-high, where the device holds steady
	task get_bit(output logic b);
		#20 sda_low = 1'b0;
		#20 scl = 1'b1;
		#38 b = sda;
		#2 scl = 1'b0;
	endtask : get_bit
	// Start, address, n bytes out or in, stop
	task xfer(input logic [7:0] adr, input logic [23:0] w, input int n);
		logic [7:0] d;
		int i;
		int k;
		#3 sda_low = 1'b1;
		#40 scl = 1'b0;
		for (i = 7; i >= 0; i--) put_bit(adr[i]);
		get_bit(ack);
		post({7'h00, ack});
		for (k = 0; k < n && !ack; k++) begin
			if (adr[0]) begin
				for (i = 7; i >= 0; i--) get_bit(d[i]);
				post(d);
				put_bit(k == n - 1);
			end else begin
				d = w[23:16];
				w = w << 8;
				for (i = 7; i >= 0; i--) put_bit(d[i]);
				get_bit(ack);
				post({7'h00, ack});
			end
		end
		#20 sda_low = 1'b1;
		#20 scl = 1'b1;
		#40 sda_low = 1'b0;
		#200;
	endtask : xfer
endmodule : host_model
`default_nettype wire

// *** verif/compass_i2c_command_interpreter_bench.sv ***
// Self-checking bench of the compass command interpreter
`timescale 1ns/1ps
`default_nettype none
module compass_i2c_command_interpreter_bench;
	import compass_pkg::*;
	logic clk, rst_b, scl, sda_low, sda_oe, sda_out, rx_done;
	logic meas_start, offset_update, cal_active, cal_finish, asleep;
	logic [7:0] rx_data, out_mode, settle_ms, sum_count, rnd;
	logic [15:0] heading_in, x_offset, y_offset;
	logic [31:0] ofs;
	run_mode_e run_mode;
	wire sda;
	logic [15:0] q[$];
	int n_mismatch, cmp_count, cyc, n_meas, n_ofs, n_cal, i;
	// Open-drain line with pull-up
	assign sda = (sda_low || sda_oe) ? 1'b0 : 1'b1;
	compass_i2c_cmd #(.NV_CYC(20),
		.HDG_CYC(60), .CALX_CYC(400)) dut_u (.clk, .rst_b, .scl,
		.sda_in(sda), .sda_out, .sda_oe, .heading_in, .meas_start,
		.offset_update, .cal_active, .cal_finish, .asleep, .run_mode,
		.out_mode, .x_offset, .y_offset, .settle_ms, .sum_count);
	host_model host_u (.scl, .sda_low, .sda, .rx_data, .rx_done);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : lfsr
	task chk(input string nm, input logic [15:0] s, e);
		cmp_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("FAIL %s exp %h seen %h", nm, e, s);
		end
	endtask : chk
	task wrap_up;
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up
	// Write frame: every byte expects an ack, then the command delay
	task cmd(input logic [23:0] w, input int n, input int wt);
		repeat (n + 1) q.push_back(16'h0000);
		host_u.xfer(8'h42, w, n);
		repeat (wt) @(posedge clk);
	endtask : cmd
	// Read frame; n of zero means the address must be refused
	task rd(input logic [15:0] e, input int n);
		q.push_back({15'h0000, n == 0});
		if (n > 0) q.push_back({8'h00, e[15:8]});
		if (n > 1) q.push_back({8'h00, e[7:0]});
		host_u.xfer(8'h43, 24'h000000, n);
		repeat (20) @(posedge clk);
	endtask : rd
	// Oldest note against each result the host sees
	always @(posedge rx_done) chk("bus byte", {8'h00, rx_data}, q.pop_front());
	// Strobe counters and hang guard; long waits are cut here
	always @(posedge clk) begin
		n_meas <= n_meas + (meas_start === 1'b1);
		n_ofs <= n_ofs + (offset_update === 1'b1);
		n_cal <= n_cal + (cal_finish === 1'b1);
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	initial begin
		rst_b <= 1'b0;
		heading_in <= 16'h0000;
		rnd = 8'h02;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		repeat (5) @(posedge clk);
		chk("sum", sum_count, 16'h0004);
		chk("settle", settle_ms, 16'h0001);
		chk("outmode", out_mode, 16'h0000);
		chk("mode", run_mode, MODE_STANDBY);
		$display("test reset done");
		rnd = lfsr(rnd);
		cmd({8'h47, 8'h30, rnd}, 3, 100);
		cmd({8'h67, 8'h30, 8'h00}, 2, 100);
		rd({rnd, 8'h00}, 1);
		$display("test ram done");
		for (i = 1; i <= 4; i++) begin
			rnd = lfsr(rnd);
			ofs = {ofs[23:0], rnd};
			cmd({8'h77, i[7:0], rnd}, 3, 100);
		end
		chk("xofs", x_offset, ofs[31:16]);
		chk("yofs", y_offset, ofs[15:0]);
		cmd({8'h77, 8'h05, rnd}, 3, 100);
		chk("settle", settle_ms, rnd);
		cmd({8'h77, 8'h06, 8'h11}, 3, 100);
		chk("sum", sum_count, 16'h0004);
		cmd({8'h72, 8'h05, 8'h00}, 2, 100);
		rd({rnd, 8'h00}, 1);
		$display("test storage done");
		chk("no measure", n_meas, 16'h0000);
		rnd = lfsr(rnd);
		heading_in <= {rnd, ~rnd};
		cmd({8'h41, 16'h0000}, 1, 100);
		rd({rnd, ~rnd}, 2);
		chk("measure", n_meas, 16'h0001);
		$display("test heading done");
		cmd({8'h43, 16'h0000}, 1, 1100);
		chk("cal", cal_active, 16'h0001);
		cmd({8'h45, 16'h0000}, 1, 0);
		rd(16'h0000, 0);
		chk("cal end", n_cal, 16'h0001);
		repeat (500) @(posedge clk);
		chk("cal", cal_active, 16'h0000);
		cmd({8'h4f, 16'h0000}, 1, 100);
		chk("offset", n_ofs, 16'h0001);
		$display("test calibration done");
		cmd({8'h53, 16'h0000}, 1, 1100);
		chk("sleep", asleep, 16'h0001);
		cmd({8'h4f, 16'h0000}, 1, 100);
		chk("offset", n_ofs, 16'h0001);
		cmd({8'h57, 16'h0000}, 1, 10100);
		chk("sleep", asleep, 16'h0000);
		$display("test sleep done");
		cmd({8'h47, 8'h74, 8'h51}, 3, 100);
		chk("mode", run_mode, MODE_QUERY);
		cmd({8'h4c, 16'h0000}, 1, 12600);
		cmd({8'h72, 8'h08, 8'h00}, 2, 100);
		rd(16'h5100, 1);
		chk("query measure", n_meas, 16'h0002);
		// Result fetch by 0x43 in query, then in continuous mode
		rnd = lfsr(rnd);
		heading_in <= {~rnd, rnd};
		cmd({8'h43, 16'h0000}, 1, 20);
		rd({~rnd, rnd}, 2);
		chk("query measure", n_meas, 16'h0003);
		cmd({8'h47, 8'h74, 8'h52}, 3, 100);
		chk("mode", run_mode, MODE_CONT);
		cmd({8'h43, 16'h0000}, 1, 20);
		rd({~rnd, rnd}, 2);
		chk("cont measure", n_meas, 16'h0003);
		$display("test mode done");
		cmd({8'h77, 8'h00, 8'h60}, 3, 100);
		q.push_back(16'h0001);
		host_u.xfer(8'h42, 24'h000000, 0);
		q.push_back(16'h0000);
		host_u.xfer(8'h60, 24'h000000, 0);
		$display("test address done");
		repeat (20) @(posedge clk);
		wrap_up();
	end
endmodule : compass_i2c_command_interpreter_bench
`default_nettype wire
